//--- hdl/tmcs_pkg.sv
package tmcs_pkg;

    // Register word offsets (byte addresses)
    localparam logic [7:0] TMCS_OFF_CSR0 = 8'h00;
    localparam logic [7:0] TMCS_OFF_CSR1 = 8'h04;
    localparam logic [7:0] TMCS_OFF_CSR2 = 8'h08;
    localparam logic [7:0] TMCS_OFF_CSR3 = 8'h0C;
    localparam logic [7:0] TMCS_OFF_IEN0 = 8'h10;
    localparam logic [7:0] TMCS_OFF_IEN1 = 8'h14;
    localparam logic [7:0] TMCS_OFF_IEN2 = 8'h18;
    localparam logic [7:0] TMCS_OFF_IEN3 = 8'h1C;
    localparam logic [7:0] TMCS_OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] TMCS_OFF_IRQ_MASK = 8'h24;

    // Field positions in the control/status register
    localparam int TMCS_BIT_COMPARE_FLAG_B = 7;
    localparam int TMCS_BIT_COMPARE_FLAG_A = 6;
    localparam int TMCS_BIT_OVF = 5;
    localparam int TMCS_BIT_ADC_TRIGGER_ENABLE = 4;
    localparam int TMCS_BIT_OSB = 2;
    localparam int TMCS_BIT_OSA = 0;

    // Reset values
    localparam logic [7:0] TMCS_CSR0_RST = 8'h00;
    localparam logic [7:0] TMCS_CSR_ODD_RST = 8'h10;
    localparam logic [7:0] TMCS_IEN_RST = 8'h00;
    localparam logic [11:0] TMCS_IRQ_MASK_RST = 12'h000;
    localparam logic [3:0] TMCS_ODD_CHANNELS = 4'b1010;

    // Output-select codes
    typedef enum logic [1:0] {
        TMCS_OS_KEEP,
        TMCS_OS_LOW,
        TMCS_OS_HIGH,
        TMCS_OS_TOGGLE
    } tmcs_os_t;

    // Timer events of one channel
    typedef struct packed {
        logic matchB;
        logic matchA;
        logic overflow;
    } tmcs_event_t;

endpackage

//--- hdl/tmcs_channel.sv
`timescale 1ns/1ps
module tmcs_channel
    import tmcs_pkg::*;
#(
    parameter bit HAS_ADC_TRIGGER_ENABLE = 1'b0,
    parameter bit ODD_RESERVED = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Timer events
    input tmcs_event_t evt,
    input wire logic xferClrB,
    input wire logic xferClrA,
    // Register access
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] wrData,
    // State
    output logic [7:0] csr,
    output logic timerOut,
    output logic adcStart
);

    logic [2:0] flags;
    logic [2:0] armed;
    logic [4:0] ctrl;
    logic [2:0] clrReq;

    // Output level after a compare event
    function automatic logic applySel(input logic [1:0] sel, input logic cur);
        case (tmcs_os_t'(sel))
            TMCS_OS_KEEP: applySel = cur;
            TMCS_OS_LOW: applySel = 1'b0;
            TMCS_OS_HIGH: applySel = 1'b1;
            TMCS_OS_TOGGLE: applySel = ~cur;
            default: applySel = cur;
        endcase
    endfunction

    // Clear needs an earlier read seeing 1, then a 0 write; events win
    always_comb begin
        clrReq[2] = (wrEn & ~wrData[TMCS_BIT_COMPARE_FLAG_B] & armed[2]) | xferClrB;
        clrReq[1] = (wrEn & ~wrData[TMCS_BIT_COMPARE_FLAG_A] & armed[1]) | xferClrA;
        clrReq[0] = wrEn & ~wrData[TMCS_BIT_OVF] & armed[0];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags <= 3'b000;
        end else begin
            // Writing 1 never sets; set wins over clear
            flags <= (flags & ~clrReq) | {evt.matchB, evt.matchA, evt.overflow};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            armed <= 3'b000;
        end else if (rdEn) begin
            armed <= flags;
        end else begin
            armed <= armed & flags & ~clrReq;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= 5'b00000;
        end else if (wrEn) begin
            ctrl[3:0] <= wrData[3:0];
            ctrl[4] <= HAS_ADC_TRIGGER_ENABLE ? wrData[TMCS_BIT_ADC_TRIGGER_ENABLE] : 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            timerOut <= 1'b0;
        end else if (evt.matchB && evt.matchA) begin
            timerOut <= applySel(ctrl[1:0], applySel(ctrl[3:2], timerOut));
        end else if (evt.matchB) begin
            timerOut <= applySel(ctrl[3:2], timerOut);
        end else if (evt.matchA) begin
            timerOut <= applySel(ctrl[1:0], timerOut);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            adcStart <= 1'b0;
        end else begin
            adcStart <= HAS_ADC_TRIGGER_ENABLE & ctrl[4] & evt.matchA;
        end
    end

    always_comb begin
        csr = {flags, ctrl};
        if (ODD_RESERVED) begin
            csr[TMCS_BIT_ADC_TRIGGER_ENABLE] = 1'b1;
        end
    end

endmodule // tmcs_channel

//--- hdl/timer8_control_status.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Compare-B flag bit 7 sets on match B; clear by read-as-1 then write 0.
// - Compare-A flag bit 6 sets on match A; clear by read-as-1 then write 0.
// - Overflow flag bit 5 sets on FF-to-00 wrap; clear by read then write 0.
// - Transfer controller service clears compare flag when its disable-select is 0.
// - Writing 0 clears a flag, writing 1 does nothing.
// - Channel 0 bit 4 enables A/D start on match A; resets to 0.
// - Match B drives output per bits 3:2: keep, low, high, toggle.
// - Match A drives output per bits 1:0: keep, low, high, toggle.
// - Channels 1 and 3 bit 4 reads 1, writes ignored.
// - Each flag requests its interrupt only while its enable bit is 1.
module timer8_control_status
    import tmcs_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer events per channel
    input tmcs_event_t [NUM_CH-1:0] timerEvt,
    // Transfer controller service, per channel
    input wire logic [NUM_CH-1:0] xferStartB,
    input wire logic [NUM_CH-1:0] xferStartA,
    input wire logic [NUM_CH-1:0] xferDisableSel,
    // Outputs
    output logic [NUM_CH-1:0] timerOut,
    output logic adcStart,
    output logic [NUM_CH-1:0] compareIrqB,
    output logic [NUM_CH-1:0] compareIrqA,
    output logic [NUM_CH-1:0] overflowIrq,
    output logic irq
);

    logic [NUM_CH-1:0][7:0] csr;
    logic [NUM_CH-1:0][2:0] irqEnable;
    logic [NUM_CH-1:0] adcReq;
    logic [3*NUM_CH-1:0] irqStat;
    logic [3*NUM_CH-1:0] irqMask;
    logic [3*NUM_CH-1:0] newEvt;
    logic [31:0] next_prdata;
    logic access;
    logic wrAcc;
    logic rdAcc;
    logic mapped;

    // Channel index of a status offset, or NUM_CH when none
    function automatic int csrIndex(input logic [7:0] addr);
        csrIndex = NUM_CH;
        case (addr)
            TMCS_OFF_CSR0: csrIndex = 0;
            TMCS_OFF_CSR1: csrIndex = 1;
            TMCS_OFF_CSR2: csrIndex = 2;
            TMCS_OFF_CSR3: csrIndex = 3;
            default: csrIndex = NUM_CH;
        endcase
    endfunction

    function automatic int ienIndex(input logic [7:0] addr);
        ienIndex = NUM_CH;
        case (addr)
            TMCS_OFF_IEN0: ienIndex = 0;
            TMCS_OFF_IEN1: ienIndex = 1;
            TMCS_OFF_IEN2: ienIndex = 2;
            TMCS_OFF_IEN3: ienIndex = 3;
            default: ienIndex = NUM_CH;
        endcase
    endfunction

    // Zero-wait APB
    assign access = psel & penable;
    assign wrAcc = access & pwrite;
    // Reads act at setup, where read data is captured: arming and clear see what was read
    assign rdAcc = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign mapped = (csrIndex(paddr) < NUM_CH) || (ienIndex(paddr) < NUM_CH)
        || (paddr == TMCS_OFF_IRQ_STAT) || (paddr == TMCS_OFF_IRQ_MASK);
    assign pslverr = access & ~mapped;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic chWr;
            logic chRd;
            assign chWr = wrAcc && (csrIndex(paddr) == ch);
            assign chRd = rdAcc && (csrIndex(paddr) == ch);

            tmcs_channel #(
                .HAS_ADC_TRIGGER_ENABLE(ch == 0),
                .ODD_RESERVED(TMCS_ODD_CHANNELS[ch % 4])
            ) u_channel (
                .clk(clk),
                .sys_rst(sys_rst),
                .evt(timerEvt[ch]),
                .xferClrB(xferStartB[ch] & ~xferDisableSel[ch]),
                .xferClrA(xferStartA[ch] & ~xferDisableSel[ch]),
                .wrEn(chWr),
                .rdEn(chRd),
                .wrData(pwdata[7:0]),
                .csr(csr[ch]),
                .timerOut(timerOut[ch]),
                .adcStart(adcReq[ch])
            );

            // Interrupt enables: bit 2 compare B, bit 1 compare A, bit 0 overflow
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    irqEnable[ch] <= TMCS_IEN_RST[2:0];
                end else if (wrAcc && (ienIndex(paddr) == ch)) begin
                    irqEnable[ch] <= pwdata[2:0];
                end
            end

            assign compareIrqB[ch] = csr[ch][TMCS_BIT_COMPARE_FLAG_B] & irqEnable[ch][2];
            assign compareIrqA[ch] = csr[ch][TMCS_BIT_COMPARE_FLAG_A] & irqEnable[ch][1];
            assign overflowIrq[ch] = csr[ch][TMCS_BIT_OVF] & irqEnable[ch][0];
            assign newEvt[3*ch +: 3] = {timerEvt[ch].matchB, timerEvt[ch].matchA,
                timerEvt[ch].overflow};
        end
    endgenerate

    assign adcStart = adcReq[0];

    // Sticky event summary, cleared by read; new events win
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqStat <= '0;
        end else if (rdAcc && paddr == TMCS_OFF_IRQ_STAT) begin
            irqStat <= newEvt;
        end else begin
            irqStat <= irqStat | newEvt;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irqMask <= TMCS_IRQ_MASK_RST[3*NUM_CH-1:0];
        end else if (wrAcc && paddr == TMCS_OFF_IRQ_MASK) begin
            irqMask <= pwdata[3*NUM_CH-1:0];
        end
    end

    assign irq = |(irqStat & irqMask);

    // Read data registered at the setup phase, valid during access
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (csrIndex(paddr) < NUM_CH) begin
            next_prdata[7:0] = csr[csrIndex(paddr)];
        end else if (ienIndex(paddr) < NUM_CH) begin
            next_prdata[2:0] = irqEnable[ienIndex(paddr)];
        end else if (paddr == TMCS_OFF_IRQ_STAT) begin
            next_prdata[3*NUM_CH-1:0] = irqStat;
        end else if (paddr == TMCS_OFF_IRQ_MASK) begin
            next_prdata[3*NUM_CH-1:0] = irqMask;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= next_prdata;
        end
    end

endmodule // timer8_control_status

//--- verification/tmcs_chk.sv
`timescale 1ns/1ps
module tmcs_chk
    import tmcs_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Timer side
    input tmcs_event_t [NUM_CH-1:0] timerEvt,
    input wire logic [NUM_CH-1:0] xferStartA,
    input wire logic [NUM_CH-1:0] xferDisableSel,
    input wire logic [NUM_CH-1:0] timerOut,
    input wire logic adcStart,
    input wire logic [NUM_CH-1:0] compareIrqB,
    input wire logic [NUM_CH-1:0] compareIrqA,
    input wire logic [NUM_CH-1:0] overflowIrq
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    wire logic wrAcc = psel && penable && pwrite;
    a_adc_cause: assert property (adcStart |-> $past(timerEvt[0].matchA))
        else $error("adc start without match a");
    a_outb_cause: assert property ($changed(timerOut[0]) |->
        $past(timerEvt[0].matchA || timerEvt[0].matchB)) else $error("output 0 moved alone");
    a_outa_cause: assert property ($changed(timerOut[2]) |->
        $past(timerEvt[2].matchA || timerEvt[2].matchB)) else $error("output 2 moved alone");
    a_cmpb_rise: assert property ($rose(compareIrqB[1]) |->
        $past(timerEvt[1].matchB || wrAcc)) else $error("irq b rose without cause");
    a_cmpa_rise: assert property ($rose(compareIrqA[1]) |->
        $past(timerEvt[1].matchA || wrAcc)) else $error("irq a rose without cause");
    a_ovf_rise: assert property ($rose(overflowIrq[1]) |->
        $past(timerEvt[1].overflow || wrAcc)) else $error("overflow irq without cause");
    a_xfer_clear: assert property (xferStartA[0] && !xferDisableSel[0]
        && !timerEvt[0].matchA |=> !compareIrqA[0]) else $error("flag a not cleared");
    a_bad_addr: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
        else $error("unmapped access without error");
    a_no_wait: assert property (psel && penable |-> pready) else $error("wait state seen");
endmodule // tmcs_chk

bind timer8_control_status tmcs_chk #(.NUM_CH(NUM_CH)) u_tmcs_chk (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .timerEvt(timerEvt),
    .xferStartA(xferStartA), .xferDisableSel(xferDisableSel), .timerOut(timerOut),
    .adcStart(adcStart), .compareIrqB(compareIrqB), .compareIrqA(compareIrqA),
    .overflowIrq(overflowIrq));

//--- verification/tb_timer8_control_status.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_timer8_control_status;
    import tmcs_pkg::*;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic adcStart, irq, err, adcSeen;
    tmcs_event_t [3:0] timerEvt = '0;
    logic [3:0] xferStartB = 0, xferStartA = 0, xferDisableSel = 0, outM = 0;
    logic [3:0] timerOut, compareIrqB, compareIrqA, overflowIrq;
    int errors = 0, num_checks = 0;
    timer8_control_status #(.NUM_CH(4)) u_timer8_control_status (.clk(clk),
        .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerEvt(timerEvt), .xferStartB(xferStartB), .xferStartA(xferStartA),
        .xferDisableSel(xferDisableSel), .timerOut(timerOut), .adcStart(adcStart),
        .compareIrqB(compareIrqB), .compareIrqA(compareIrqA), .overflowIrq(overflowIrq),
        .irq(irq));
    initial forever #25 clk = ~clk;
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One transfer; optional event pulse lands on the access edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input tmcs_event_t ev = '0, input int ch = 0);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        timerEvt[ch] <= ev;
        @(posedge clk);
        timerEvt[ch] <= '0;
        while (pready !== 1'b1) begin
            n++;
            if (n > 16) begin
                errors++;
                end_of_test();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input int ch, input tmcs_event_t ev);
        timerEvt[ch] <= ev;
        @(posedge clk);
        timerEvt[ch] <= '0;
        // One-cycle start pulse, sampled mid-cycle while it stands
        @(negedge clk);
        adcSeen = adcStart;
        @(posedge clk);
    endtask
    function automatic logic nextOut(logic o, logic [1:0] c);
        return (c == 2'h0) ? o : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? 1'b1 : ~o;
    endfunction
    initial begin
        int ch, b;
        logic [7:0] v, base;
        tmcs_event_t ev;
        void'($urandom(32'h5826));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (ch = 0; ch < 4; ch++) begin
            base = (ch % 2) ? 8'h10 : 8'h00;
            apb(1'b0, 8'(ch * 4), 32'h0);
            `CHK("csr reset", base, rd[7:0])
            apb(1'b1, 8'(ch * 4), 32'h0000_00ff);
            apb(1'b0, 8'(ch * 4), 32'h0);
            `CHK("csr ones", (ch == 2) ? 8'h0f : 8'h1f, rd[7:0])
            apb(1'b1, 8'(ch * 4), 32'h0);
            apb(1'b0, 8'(ch * 4), 32'h0);
            `CHK("csr zeros", base, rd[7:0])
            for (b = 0; b < 3; b++) begin
                v = 8'h80 >> b;
                pulse(ch, 3'b100 >> b);
                apb(1'b1, 8'(ch * 4), 32'h0);
                apb(1'b0, 8'(ch * 4), 32'h0);
                `CHK("unarmed clear", base | v, rd[7:0])
                apb(1'b1, 8'(ch * 4), {24'h0, v});
                apb(1'b1, 8'(ch * 4), 32'h0, 3'b100 >> b, ch);
                apb(1'b0, 8'(ch * 4), 32'h0);
                `CHK("clear against event", base | v, rd[7:0])
                apb(1'b1, 8'(ch * 4), 32'h0);
                apb(1'b0, 8'(ch * 4), 32'h0);
                `CHK("armed clear", base, rd[7:0])
            end
        end
        // All output codes first, then random settings and events
        for (int i = 0; i < 40; i++) begin
            ch = $urandom % 4;
            v = (i < 16) ? 8'(i) : 8'($urandom % 32);
            ev = (i < 16) ? 3'b110 : 3'(($urandom % 4) << 1);
            apb(1'b1, 8'(ch * 4), {24'h0, v});
            pulse(ch, ev);
            `CHK("adc start", ch == 0 && v[4] && ev.matchA, adcSeen)
            if (ev.matchB) outM[ch] = nextOut(outM[ch], v[3:2]);
            if (ev.matchA) outM[ch] = nextOut(outM[ch], v[1:0]);
            `CHK("timer out", outM, timerOut)
        end
        for (int k = 0; k < 4; k++) begin
            pulse(0, 3'b110);
            xferDisableSel[0] <= k[1];
            xferStartA[0] <= k[0];
            xferStartB[0] <= !k[0];
            @(posedge clk);
            xferStartA <= '0;
            xferStartB <= '0;
            apb(1'b0, TMCS_OFF_CSR0, 32'h0);
            `CHK("transfer clear a", k[1] | ~k[0], rd[6])
            `CHK("transfer clear b", k[1] | k[0], rd[7])
        end
        pulse(1, 3'b111);
        apb(1'b1, TMCS_OFF_IEN1, 32'h0000_0005);
        `CHK("irq gate", 3'b101, {compareIrqB[1], compareIrqA[1], overflowIrq[1]})
        apb(1'b1, TMCS_OFF_IEN1, 32'h0000_0002);
        `CHK("irq gate a", 3'b010, {compareIrqB[1], compareIrqA[1], overflowIrq[1]})
        apb(1'b0, TMCS_OFF_IRQ_STAT, 32'h0);
        pulse(2, 3'b001);
        `CHK("masked irq", 1'b0, irq)
        apb(1'b1, TMCS_OFF_IRQ_MASK, 32'h0000_0040);
        `CHK("irq level", 1'b1, irq)
        apb(1'b0, TMCS_OFF_IRQ_STAT, 32'h0);
        `CHK("irq status", 32'h0000_0040, rd)
        `CHK("mapped no error", 1'b0, err)
        `CHK("irq after read", 1'b0, irq)
        apb(1'b0, 8'h30, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        end_of_test();
    end
endmodule // tb_timer8_control_status
